// ### core/serial_rom_pkg.sv
/*
 * Shared constants and types of the serial ROM command front end.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package serial_rom_pkg;

   // ==========================================================
   // Opcodes
   localparam logic [7:0] OP_ARRAY_READ          = 8'h03;
   localparam logic [7:0] OP_ARRAY_READ_DUMMY    = 8'h0B;
   localparam logic [7:0] identification_fetch_cmd = 8'h9F;

   // ==========================================================
   // Frame shape
   localparam int         ADDR_BITS     = 23;
   localparam logic [1:0] ADDR_LAST_IDX = 2'h2;  // Index of address_byte_low
   localparam logic [1:0] ID_BYTES      = 2'h3;
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam logic [2:0] BIT_FIRST     = 3'h0;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      st_cmd,
      st_addr,
      st_dummy,
      st_data,
      st_ident,
      st_standby
   } phase_type;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic si;
   } link_pins_type;

endpackage

// ### core/link_sampler.sv
/*
 * Two-flop synchroniser with edge detection for a group of pins.
 * Assumes the pins are asynchronous to mclk and change slower than mclk.
 */
`timescale 1ns/1ns
module link_sampler #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Raw pins
   input  wire logic [W-1:0] raw,
   // Sampled level and edges
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   // ==========================================================
   // Synchroniser chain; meta_q feeds only sync_q
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_q <= '1;
         sync_q <= '1;
         prev_q <= '1;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge decode from settled stages
   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;
   assign fall  = ~sync_q & prev_q;

endmodule

// ### core/serial_rom_command_reader.sv
/*
 * Serial command front end of a byte-organised read-only memory.
 * Assumes a byte array on mclk answers array_addr with array_byte in one cycle,
 * and that the serial clock is well below mclk/4.
 */
// Contract
// - Opcode 03 plus three address bytes reads
// - Address 23 bits, high byte first, top ignored
// - Opcode 0B, address, dummy byte then data
// - Data streams while select stays low
// - Opcode 9F returns three identification bytes
// - First byte picks active or standby
// - Array read stays active until select high
// - Bad opcode: standby until select high
// - Output tri-stated during standby
// - Select high abandons command, enters standby; code returns phase to st_cmd, output tri-stated
// - Bad opcode enters standby next rising edge
// - Output changes on falling serial edge
// - Input sampled on rising serial edge
// - All bytes travel most significant bit first
// - First data bit at fall in bit0
`timescale 1ns/1ns
module serial_rom_command_reader #(
   parameter logic [7:0] ID_MAKER = 8'h5A,  // Arbitrary value
   parameter logic [7:0] ID_TYPE  = 8'h3C,  // Arbitrary value
   parameter logic [7:0] ID_SIZE  = 8'h01,  // Arbitrary value
   parameter int         ADDR_W   = serial_rom_pkg::ADDR_BITS
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // Serial link pins
   input  wire logic              cs_n,
   input  wire logic              sclk,
   input  wire logic              si,
   output logic                   so_out,
   output logic                   so_oe_n,
   // Memory array port
   output logic      [ADDR_W-1:0] array_addr,
   input  wire logic [7:0]        array_byte
);

   serial_rom_pkg::link_pins_type pin_raw;
   serial_rom_pkg::link_pins_type pin_lvl;
   serial_rom_pkg::link_pins_type pin_rise;
   serial_rom_pkg::link_pins_type pin_fall;
   serial_rom_pkg::phase_type     phase_q;
   serial_rom_pkg::phase_type     phase_d;
   logic              fast_q;
   logic              fast_d;
   logic [7:0]        in_q;
   logic [2:0]        bit_cnt_q;
   logic [1:0]        byte_cnt_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0]        out_sh_q;
   logic [2:0]        out_cnt_q;
   logic [1:0]        id_idx_q;
   logic              so_q;
   logic              oe_n_q;
   logic              first_due_q;

   // ==========================================================
   // Pin sampling
   assign pin_raw = '{cs_n: cs_n, sclk: sclk, si: si};

   link_sampler #(
      .W(3)
   ) u_sampler (
      .mclk  (mclk),
      .rst   (rst),
      .raw   (pin_raw),
      .level (pin_lvl),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   // Edge events inside a selected frame
   wire       cs_high   = pin_lvl.cs_n;
   wire       take_bit  = pin_rise.sclk & ~cs_high;
   wire       take_fall = pin_fall.sclk & ~cs_high;
   wire [7:0] rx_byte   = {in_q[6:0], pin_lvl.si};
   wire       byte_done = take_bit & (bit_cnt_q == serial_rom_pkg::BIT_LAST);
   wire       in_data   = (phase_q == serial_rom_pkg::st_data);
   wire       in_ident  = (phase_q == serial_rom_pkg::st_ident);
   wire       id_end    = (id_idx_q == serial_rom_pkg::ID_BYTES);
   wire       byte_edge = take_fall & (out_cnt_q == serial_rom_pkg::BIT_FIRST);
   wire       load_byte = byte_edge & (in_data | (in_ident & ~id_end));
   wire       ident_fin = byte_edge & in_ident & id_end;

   // Identification byte selection
   wire [7:0] id_byte = (id_idx_q == 2'h0) ? ID_MAKER :
                        (id_idx_q == 2'h1) ? ID_TYPE : ID_SIZE;
   wire [7:0] src_byte = in_data ? array_byte : id_byte;

   assign array_addr = addr_q;
   assign so_out     = so_q;
   assign so_oe_n    = oe_n_q;

   // ==========================================================
   // Command phase sequencing
   always_comb begin
      phase_d = phase_q;
      fast_d  = fast_q;
      if (cs_high) begin
         phase_d = serial_rom_pkg::st_cmd;
      end else if (byte_done) begin
         unique case (phase_q)
            serial_rom_pkg::st_cmd: begin
               if (rx_byte == serial_rom_pkg::OP_ARRAY_READ) begin
                  phase_d = serial_rom_pkg::st_addr;
                  fast_d  = 1'b0;
               end else if (rx_byte == serial_rom_pkg::OP_ARRAY_READ_DUMMY) begin
                  phase_d = serial_rom_pkg::st_addr;
                  fast_d  = 1'b1;
               end else if (rx_byte == serial_rom_pkg::identification_fetch_cmd) begin
                  phase_d = serial_rom_pkg::st_ident;
               end else begin
                  phase_d = serial_rom_pkg::st_standby;
               end
            end
            serial_rom_pkg::st_addr: begin
               if (byte_cnt_q == serial_rom_pkg::ADDR_LAST_IDX) begin
                  phase_d = fast_q ? serial_rom_pkg::st_dummy : serial_rom_pkg::st_data;
               end
            end
            serial_rom_pkg::st_dummy: begin
               phase_d = serial_rom_pkg::st_data;
            end
            serial_rom_pkg::st_data,
            serial_rom_pkg::st_ident,
            serial_rom_pkg::st_standby: begin
               phase_d = phase_q;
            end
         endcase
      end else if (ident_fin) begin
         phase_d = serial_rom_pkg::st_standby;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_q <= serial_rom_pkg::st_cmd;
         fast_q  <= 1'b0;
      end else begin
         phase_q <= phase_d;
         fast_q  <= fast_d;
      end
   end

   // ==========================================================
   // Input shifter and counters
   always_ff @(posedge mclk) begin
      if (rst || cs_high) begin
         in_q       <= 8'h00;
         bit_cnt_q  <= serial_rom_pkg::BIT_FIRST;
         byte_cnt_q <= 2'h0;
      end else if (take_bit) begin
         in_q       <= rx_byte;
         bit_cnt_q  <= bit_cnt_q + 3'h1;
         if (byte_done && phase_q == serial_rom_pkg::st_addr) begin
            byte_cnt_q <= byte_cnt_q + 2'h1;
         end
      end
   end

   // Address capture and post-increment
   always_ff @(posedge mclk) begin
      if (rst) begin
         addr_q <= '0;
      end else if (byte_done && phase_q == serial_rom_pkg::st_addr) begin
         addr_q <= ADDR_W'({addr_q, rx_byte});
      end else if (load_byte && in_data) begin
         addr_q <= addr_q + ADDR_W'(1);
      end
   end

   // ==========================================================
   // Output shifter, changes on serial falling edges and clears on deselect
   always_ff @(posedge mclk) begin
      if (rst || cs_high) begin
         out_sh_q  <= 8'h00;
         out_cnt_q <= serial_rom_pkg::BIT_FIRST;
         id_idx_q  <= 2'h0;
         so_q      <= 1'b0;
      end else if (load_byte) begin
         so_q      <= src_byte[7];
         out_sh_q  <= {src_byte[6:0], 1'b0};
         out_cnt_q <= out_cnt_q + 3'h1;
         id_idx_q  <= in_ident ? id_idx_q + 2'h1 : id_idx_q;
      end else if (take_fall && (in_data || in_ident) && !ident_fin) begin
         so_q      <= out_sh_q[7];
         out_sh_q  <= {out_sh_q[6:0], 1'b0};
         out_cnt_q <= out_cnt_q + 3'h1;
      end
   end

   // Output enable, low while driving
   always_ff @(posedge mclk) begin
      if (rst || cs_high || phase_q == serial_rom_pkg::st_standby) begin
         oe_n_q <= 1'b1;
      end else if (ident_fin) begin
         oe_n_q <= 1'b1;
      end else if (load_byte) begin
         oe_n_q <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions

   // Marks the wait between entering data and the first serial fall
   always_ff @(posedge mclk) begin
      if (rst || cs_high || take_fall) begin
         first_due_q <= 1'b0;
      end else if (phase_d == serial_rom_pkg::st_data && !in_data) begin
         first_due_q <= 1'b1;
      end
   end

   a_standby_hiz: assert property (@(posedge mclk) disable iff (rst)
      phase_q == serial_rom_pkg::st_standby |=> so_oe_n)
      else $error("output driven in standby");

   a_deselect_abort: assert property (@(posedge mclk) disable iff (rst)
      cs_high |=> phase_q == serial_rom_pkg::st_cmd ##1 so_oe_n)
      else $error("deselect did not abandon command");

   a_bad_opcode: assert property (@(posedge mclk) disable iff (rst)
      byte_done && phase_q == serial_rom_pkg::st_cmd && rx_byte != serial_rom_pkg::OP_ARRAY_READ
      && rx_byte != serial_rom_pkg::OP_ARRAY_READ_DUMMY && rx_byte != serial_rom_pkg::identification_fetch_cmd
      |=> phase_q == serial_rom_pkg::st_standby)
      else $error("bad opcode not sent to standby");

   a_standby_stays: assert property (@(posedge mclk) disable iff (rst)
      phase_q == serial_rom_pkg::st_standby && !cs_high |=> phase_q == serial_rom_pkg::st_standby)
      else $error("standby left while selected");

   a_read_start: assert property (@(posedge mclk) disable iff (rst)
      byte_done && phase_q == serial_rom_pkg::st_cmd && rx_byte == serial_rom_pkg::OP_ARRAY_READ
      |=> phase_q == serial_rom_pkg::st_addr && !fast_q)
      else $error("plain read not started");

   a_fast_start: assert property (@(posedge mclk) disable iff (rst)
      byte_done && phase_q == serial_rom_pkg::st_addr && byte_cnt_q == serial_rom_pkg::ADDR_LAST_IDX
      && fast_q |=> phase_q == serial_rom_pkg::st_dummy)
      else $error("dummy byte skipped");

   a_active_holds: assert property (@(posedge mclk) disable iff (rst)
      in_data && !cs_high |=> in_data)
      else $error("array read left while selected");

   a_out_on_fall: assert property (@(posedge mclk) disable iff (rst)
      !$stable(so_q) && !$past(cs_high) |-> $past(take_fall))
      else $error("output changed off falling edge");

   a_addr_step: assert property (@(posedge mclk) disable iff (rst)
      load_byte && in_data |=> addr_q == $past(addr_q) + ADDR_W'(1))
      else $error("address not advanced");

   a_addr_low: assert property (@(posedge mclk) disable iff (rst)
      byte_done && phase_q == serial_rom_pkg::st_addr |=> addr_q[7:0] == $past(rx_byte))
      else $error("address byte not captured");

   a_first_bit: assert property (@(posedge mclk) disable iff (rst)
      first_due_q && take_fall |=> !so_oe_n && so_q == $past(array_byte[7]))
      else $error("first data bit not on first fall");

   c_plain_read: cover property (@(posedge mclk) disable iff (rst) in_data && !fast_q && load_byte);
   c_fast_read:  cover property (@(posedge mclk) disable iff (rst) in_data && fast_q && load_byte);
   c_ident_done: cover property (@(posedge mclk) disable iff (rst) ident_fin);
   c_bad_opcode: cover property (@(posedge mclk) disable iff (rst) phase_q == serial_rom_pkg::st_standby);

endmodule

// ### tb/spi_host_model.sv
/*
 * Behavioural SPI host that frames reads towards the serial ROM reader.
 * Assumes mclk has a 50 ns period.
 * The bench calls its tasks, and all pins move on the falling edge of mclk.
 */
`timescale 1ns/1ns
module spi_host_model (
   // Clock
   input  wire logic mclk,
   // Link pins
   output logic      cs_n,
   output logic      sclk,
   output logic      si,
   input  wire logic so_out
);
   // ==========================================================
   // Idle pins: deselected, serial clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end

   // Select the device, leaving a short lead before the first clock
   task automatic open_frame();
      @(negedge mclk) cs_n <= 1'b0;
      repeat (2) @(negedge mclk);
   endtask

   // One byte each way, bit 7 first, 8 mclk per bit (2.5 MHz)
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(negedge mclk) sclk <= 1'b0;
         si <= tx[i];
         repeat (4) @(negedge mclk);
         rx[i] = so_out;
         sclk <= 1'b1;
         repeat (3) @(negedge mclk);
      end
   endtask

   // Deselect, leave serial data meaningless, keep the gap well above minimum
   task automatic close_frame();
      @(negedge mclk) cs_n <= 1'b1;
      si <= ~si;
      repeat (8) @(negedge mclk);
   endtask
endmodule

// ### tb/serial_rom_command_reader_tb.sv
/*
 * Self-checking bench for the serial ROM command front end.
 * Assumes spi_host_model drives the link.
 * A registered array model answers array_addr one clock later.
 */
`timescale 1ns/1ns
module serial_rom_command_reader_tb;
   // ==========================================================
   // Signals
   localparam logic [7:0] MAKER = 8'hC3;  // Arbitrary value
   localparam logic [7:0] DTYPE = 8'h96;  // Arbitrary value
   localparam logic [7:0] DSIZE = 8'h2D;  // Arbitrary value
   logic        mclk       = 1'b0;
   logic        rst        = 1'b1;
   logic [7:0]  array_byte;
   logic        cs_n, sclk, si, so_out, so_oe_n;
   logic [22:0] array_addr;
   // Released data line reads as the inverse of the last bit, so a late enable shows as bad data
   wire         so_line = so_oe_n ? ~so_out : so_out;
   int          fails      = 0;
   int          cmp_count  = 0;
   int          seed       = 63853;
   int          cycles     = 0;

   // Clock, and a cycle ceiling that cuts a hang short
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails++;
         conclude();
      end
   end

   // Array contents depend on every address byte
   function automatic logic [7:0] mem_f(input logic [22:0] a);
      return a[7:0] ^ a[15:8] ^ {1'b0, a[22:16]} ^ 8'hA5;
   endfunction
   always_ff @(posedge mclk) array_byte <= mem_f(array_addr);

   serial_rom_command_reader #(.ID_MAKER(MAKER), .ID_TYPE(DTYPE), .ID_SIZE(DSIZE)) dut (
      .mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_out),
      .so_oe_n(so_oe_n), .array_addr(array_addr), .array_byte(array_byte));
   spi_host_model host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_line));

   // ==========================================================
   // Compare tasks and verdict
   task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cmp1(input string name, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic conclude();
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Array read of n bytes, random don't-care top bit, then deselect mid-stream
   task automatic read_frame(input logic [7:0] op, input logic [22:0] a, input int n);
      logic [7:0]  rx;
      logic [7:0]  junk;
      logic [22:0] p;
      p    = a;
      junk = 8'($random(seed));
      host.open_frame();
      host.xfer(op, rx);
      host.xfer({junk[7], a[22:16]}, rx);
      host.xfer(a[15:8], rx);
      host.xfer(a[7:0], rx);
      if (op == 8'h0B) host.xfer(junk, rx);
      for (int k = 0; k < n; k++) begin
         host.xfer(8'($random(seed)), rx);
         cmp8("read data", mem_f(p), rx);
         cmp1("oe_n active", 1'b0, so_oe_n);
         p = p + 23'h1;
      end
      host.close_frame();
      cmp1("oe_n after deselect", 1'b1, so_oe_n);
   endtask

   // Bad opcode: later bytes, even a read opcode, stay ignored
   task automatic bad_frame(input logic [7:0] op);
      logic [7:0] rx;
      host.open_frame();
      host.xfer(op, rx);
      for (int k = 0; k < 5; k++) begin
         host.xfer((k == 0) ? 8'h03 : 8'($random(seed)), rx);
         cmp1("oe_n standby", 1'b1, so_oe_n);
      end
      host.close_frame();
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] rx;
      logic [7:0] op;
      logic [7:0] ids [3];
      ids = '{MAKER, DTYPE, DSIZE};
      repeat (4) @(negedge mclk);
      rst <= 1'b0;
      repeat (4) @(negedge mclk);
      cmp1("oe_n idle", 1'b1, so_oe_n);
      read_frame(8'h03, 23'h7FFFFE, 3);
      read_frame(8'h0B, 23'h7FFFFF, 2);
      for (int k = 0; k < 6; k++) begin
         op = 8'($random(seed));
         read_frame(op[0] ? 8'h0B : 8'h03, 23'($random(seed)), 1 + op[2:1]);
      end
      host.open_frame();
      host.xfer(8'h9F, rx);
      for (int k = 0; k < 3; k++) begin
         host.xfer(8'($random(seed)), rx);
         cmp8("ident byte", ids[k], rx);
      end
      host.xfer(8'h00, rx);
      cmp1("oe_n after ident", 1'b1, so_oe_n);
      host.close_frame();
      foreach (ids[k]) bad_frame(8'h02 + 8'(k * 8'h4E));
      bad_frame(8'hFF);
      repeat (3) begin
         op = 8'($random(seed));
         if (op != 8'h03 && op != 8'h0B && op != 8'h9F) bad_frame(op);
      end
      host.open_frame();
      host.xfer(8'h0B, rx);
      host.xfer(8'($random(seed)), rx);
      host.close_frame();
      read_frame(8'h03, 23'h2A5C3E, 2);
      conclude();
   end
endmodule
